// File: core/xped_params.svh
// What this block does
// - first CAN enable clear blocks first CAN and frees its two pins.
// - first CAN window goes external only when both CAN enables are clear.
// - second CAN enable clear blocks second CAN and frees its two pins.
// - second CAN window goes external only when both CAN enables are clear.
// - small RAM enable clear sends its window external; set serves internal RAM.
// - large RAM enable clear sends its window external; set serves internal RAM.
// - RTC enable clear blocks RTC; window external only if both CANs clear.
// - both CANs off sends combined CAN window to the external bus controller.
// - after reset first CAN and small RAM enabled, the rest disabled.
// - enable register writes ignored once the global enable bit is set.
// - emulation mode treats every enable bit as set.
// - RTC disabled plus power-down stops the RTC oscillator.
// - RTC enabled lets the oscillator-off bit choose power-down behaviour.
`ifndef XPED_PARAMS_SVH
`define XPED_PARAMS_SVH

// ****************************************
// register map (byte addresses)
// ****************************************
`define XPED_OFS_PEC     16'hf024
`define XPED_OFS_SYSCFG  16'hf028
`define XPED_OFS_STATUS  16'hf02c

// ****************************************
// field positions
// ****************************************
`define XPED_BIT_CAN1    0
`define XPED_BIT_CAN2    1
`define XPED_BIT_SRAM    2
`define XPED_BIT_LRAM    3
`define XPED_BIT_RTC     4
`define XPED_BIT_GLOBAL  0
`define XPED_BIT_EMUL    5
`define XPED_BIT_OSC     6
`define XPED_BIT_LOCK    7

// ****************************************
// reset values
// ****************************************
`define XPED_PEC_RESET   5'h05
`define XPED_PEC_MASK    16'h001f

// ****************************************
// address windows (24-bit, inclusive)
// ****************************************
`define XPED_CAN1_LO     24'h00ef00
`define XPED_CAN1_HI     24'h00efff
`define XPED_CAN2_LO     24'h00ee00
`define XPED_CAN2_HI     24'h00eeff
`define XPED_SRAM_LO     24'h00e000
`define XPED_SRAM_HI     24'h00e7ff
`define XPED_LRAM_LO     24'h00c000
`define XPED_LRAM_HI     24'h00dfff
`define XPED_RTC_LO      24'h00ec00
`define XPED_RTC_HI      24'h00ecff

`endif

// File: core/xped_pkg.sv
`default_nettype none
package xped_pkg;

  // ****************************************
  // enable set, bit order matches the register
  // ****************************************
  typedef struct packed {
    logic rtc;
    logic large_ext_ram_enable;
    logic small_ext_ram_enable;
    logic second_can_enable;
    logic first_can_enable;
  } xped_enables_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [15:0] address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } xped_avs_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } xped_avs_rsp_t;

  // one-hot target of a decoded cpu access; valid is cpu_req_i, registered together with the target
  typedef struct packed {
    logic valid;
    logic can1;
    logic can2;
    logic small_ram;
    logic large_ram;
    logic rtc;
    logic external;
    logic blocked;
    logic other;
  } xped_route_t;

  typedef enum logic [2:0] {
    XPED_BUS_IDLE = 3'b001,
    XPED_BUS_ACK  = 3'b010,
    XPED_BUS_DONE = 3'b100
  } xped_bus_state_t;

endpackage
`default_nettype wire

// File: core/xped_sync3.sv
`default_nettype none
module xped_sync3 (
  input  wire logic clock_i,
  input  wire logic sys_rst_i,
  input  wire logic async_i,
  output logic      level_o
);
  import xped_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } xped_sync_state_t;

  xped_sync_state_t st;
  xped_sync_state_t next_st;

  // the first stage feeds only the second; a change counts once stages 2 and 3 agree
  always_comb begin
    next_st    = st;
    next_st.s1 = async_i;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (st.s2 == st.s3) begin
      next_st.level = st.s3;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level_o = st.level;
endmodule
`default_nettype wire

// File: core/xped_top.sv
// Register access over Avalon-MM was decided locally.
`include "xped_params.svh"
`default_nettype none
module xped_top (
  input  wire logic                  clock_i,
  input  wire logic                  sys_rst_i,
  input  wire xped_pkg::xped_avs_req_t avs_req_i,
  output xped_pkg::xped_avs_rsp_t    avs_rsp_o,
  input  wire logic                  emul_mode_i,
  input  wire logic                  cpu_req_i,
  input  wire logic [23:0]           cpu_addr_i,
  input  wire logic                  power_down_i,
  input  wire logic                  rtc_oscillator_off_i,
  output xped_pkg::xped_route_t      route_o,
  output xped_pkg::xped_enables_t    periph_on_o,
  output logic                       can1_pins_gpio_o,
  output logic                       can2_pins_gpio_o,
  output logic                       rtc_osc_run_o,
  output logic                       ext_periph_locked_o
);
  import xped_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    xped_bus_state_t bus;
    logic [31:0]     readdata;
    logic            waitreq;
    xped_enables_t   pec;
    logic            global_ext_periph_enable;
    xped_route_t     route;
    xped_enables_t   on;
    logic            can1_gpio;
    logic            can2_gpio;
    logic            osc_run;
  } xped_state_t;

  xped_state_t st;
  xped_state_t next_st;

  logic          emul_level;
  xped_enables_t eff;
  xped_route_t   dec;
  logic          bus_req;
  logic          take;
  logic [31:0]   rd_mux;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic in_window(input logic [23:0] a,
                                     input logic [23:0] lo,
                                     input logic [23:0] hi);
    in_window = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [15:0] pack_enables(input xped_enables_t e);
    pack_enables = {11'h000, e};
  endfunction

  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    hit = (a[15:2] == ofs[15:2]);
  endfunction

  // ****************************************
  // emulation pin
  // ****************************************
  xped_sync3 u_emul_sync (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (emul_mode_i),
    .level_o   (emul_level)
  );

  // ****************************************
  // effective enables
  // ****************************************
  always_comb begin
    eff = st.pec;
    if (emul_level) begin
      eff = '1;
    end
  end

  // ****************************************
  // address decode
  // ****************************************
  always_comb begin
    dec       = '0;
    dec.valid = cpu_req_i;
    if (!cpu_req_i) begin
      dec = '0;
    end else if (in_window(cpu_addr_i, `XPED_CAN1_LO, `XPED_CAN1_HI)) begin
      if (eff.first_can_enable) begin
        dec.can1 = 1'b1;
      end else if (!eff.second_can_enable) begin
        dec.external = 1'b1;
      end else begin
        dec.blocked = 1'b1;
      end
    end else if (in_window(cpu_addr_i, `XPED_CAN2_LO, `XPED_CAN2_HI)) begin
      if (eff.second_can_enable) begin
        dec.can2 = 1'b1;
      end else if (!eff.first_can_enable) begin
        dec.external = 1'b1;
      end else begin
        dec.blocked = 1'b1;
      end
    end else if (in_window(cpu_addr_i, `XPED_RTC_LO, `XPED_RTC_HI)) begin
      if (eff.rtc) begin
        dec.rtc = 1'b1;
      end else if (!eff.first_can_enable && !eff.second_can_enable) begin
        dec.external = 1'b1;
      end else begin
        dec.blocked = 1'b1;
      end
    end else if (in_window(cpu_addr_i, `XPED_SRAM_LO, `XPED_SRAM_HI)) begin
      if (eff.small_ext_ram_enable) begin
        dec.small_ram = 1'b1;
      end else begin
        dec.external = 1'b1;
      end
    end else if (in_window(cpu_addr_i, `XPED_LRAM_LO, `XPED_LRAM_HI)) begin
      if (eff.large_ext_ram_enable) begin
        dec.large_ram = 1'b1;
      end else begin
        dec.external = 1'b1;
      end
    end else begin
      // outside every extension window: not this block's business
      dec.other = 1'b1;
    end
  end

  // ****************************************
  // register read mux
  // ****************************************
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit(avs_req_i.address, `XPED_OFS_PEC)) begin
      rd_mux[15:0] = pack_enables(st.pec);
    end else if (hit(avs_req_i.address, `XPED_OFS_SYSCFG)) begin
      rd_mux[`XPED_BIT_GLOBAL] = st.global_ext_periph_enable;
    end else if (hit(avs_req_i.address, `XPED_OFS_STATUS)) begin
      // live view: enables as the decoder sees them, plus mode bits
      rd_mux[4:0]              = eff;
      rd_mux[`XPED_BIT_EMUL]   = emul_level;
      rd_mux[`XPED_BIT_OSC]    = st.osc_run;
      rd_mux[`XPED_BIT_LOCK]   = st.global_ext_periph_enable;
    end
  end

  // ****************************************
  // bus slave
  // ****************************************
  // a request is answered one cycle after it appears; the write lands on the
  // edge where the master sees waitrequest low, then one idle cycle follows
  // so the still-held request is not taken twice
  assign bus_req = avs_req_i.read ^ avs_req_i.write;
  assign take    = (st.bus == XPED_BUS_ACK);

  always_comb begin
    next_st       = st;
    next_st.route = dec;

    case (st.bus)
      XPED_BUS_IDLE: begin
        if (bus_req) begin
          next_st.bus      = XPED_BUS_ACK;
          next_st.readdata = avs_req_i.read ? rd_mux : 32'h0000_0000;
          next_st.waitreq  = 1'b0;
        end
      end
      XPED_BUS_ACK: begin
        next_st.bus     = XPED_BUS_DONE;
        next_st.waitreq = 1'b1;
      end
      XPED_BUS_DONE: begin
        next_st.bus = XPED_BUS_IDLE;
      end
      default: begin
        next_st.bus = XPED_BUS_IDLE;
      end
    endcase

    if (take && avs_req_i.write && avs_req_i.byteenable[0]) begin
      if (hit(avs_req_i.address, `XPED_OFS_PEC)) begin
        if (!st.global_ext_periph_enable) begin
          next_st.pec = avs_req_i.writedata[4:0];
        end
      end else if (hit(avs_req_i.address, `XPED_OFS_SYSCFG)) begin
        // set-only: once set the enables stay frozen until reset
        if (avs_req_i.writedata[`XPED_BIT_GLOBAL]) begin
          next_st.global_ext_periph_enable = 1'b1;
        end
      end
    end

    // ****************************************
    // peripheral enables and pin release
    // ****************************************
    // first CAN on or blocked
    next_st.on.first_can_enable     = eff.first_can_enable;
    next_st.can1_gpio               = !eff.first_can_enable;
    next_st.on.second_can_enable    = eff.second_can_enable;
    next_st.can2_gpio               = !eff.second_can_enable;
    next_st.on.small_ext_ram_enable = eff.small_ext_ram_enable;
    next_st.on.large_ext_ram_enable = eff.large_ext_ram_enable;
    next_st.on.rtc                  = eff.rtc;

    // ****************************************
    // rtc oscillator
    // ****************************************
    if (!power_down_i) begin
      next_st.osc_run = 1'b1;
    end else if (!eff.rtc) begin
      next_st.osc_run = 1'b0;
    end else begin
      next_st.osc_run = !rtc_oscillator_off_i;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      st.bus                      <= XPED_BUS_IDLE;
      st.readdata                 <= 32'h0000_0000;
      st.waitreq                  <= 1'b1;
      st.pec                      <= `XPED_PEC_RESET;
      st.global_ext_periph_enable <= 1'b0;
      st.route                    <= '0;
      st.on                       <= `XPED_PEC_RESET;
      st.can1_gpio                <= 1'b0;
      st.can2_gpio                <= 1'b1;
      st.osc_run                  <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign avs_rsp_o.readdata    = st.readdata;
  assign avs_rsp_o.waitrequest = st.waitreq;
  assign route_o               = st.route;
  assign periph_on_o           = st.on;
  assign can1_pins_gpio_o      = st.can1_gpio;
  assign can2_pins_gpio_o      = st.can2_gpio;
  assign rtc_osc_run_o         = st.osc_run;
  assign ext_periph_locked_o   = st.global_ext_periph_enable;

endmodule
`default_nettype wire

// File: sim/xped_top_asserts.sv
`default_nettype none
module xped_top_asserts (
  input wire logic                    clock_i,
  input wire logic                    sys_rst_i,
  input wire xped_pkg::xped_avs_req_t avs_req_i,
  input wire xped_pkg::xped_avs_rsp_t avs_rsp_o,
  input wire logic                    emul_mode_i,
  input wire logic                    cpu_req_i,
  input wire logic [23:0]             cpu_addr_i,
  input wire logic                    power_down_i,
  input wire logic                    rtc_oscillator_off_i,
  input wire xped_pkg::xped_route_t   route_o,
  input wire xped_pkg::xped_enables_t periph_on_o,
  input wire logic                    can1_pins_gpio_o,
  input wire logic                    can2_pins_gpio_o,
  input wire logic                    rtc_osc_run_o,
  input wire logic                    ext_periph_locked_o
);
  import xped_pkg::*;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);
  // ****
  // request in a window while enables hold still
  // ****
  sequence s_req(lo, hi, en);
    cpu_req_i && en && cpu_addr_i >= lo && cpu_addr_i <= hi ##1 $stable(periph_on_o);
  endsequence
  a_route_valid: assert property (cpu_req_i |=> route_o.valid && $onehot(route_o[7:0]))
    else $error("route not one-hot after request");
  a_can1_served: assert property (
    s_req(24'h00ef00, 24'h00efff, periph_on_o.first_can_enable) |-> route_o.can1)
    else $error("first can not served");
  a_can_external: assert property (
    s_req(24'h00ee00, 24'h00efff, periph_on_o[1:0] == 2'b00) |-> route_o.external)
    else $error("can window not external");
  a_can1_blocked: assert property (
    s_req(24'h00ef00, 24'h00efff, !periph_on_o[0] && periph_on_o[1]) |-> route_o.blocked)
    else $error("shared window left internal rule");
  a_can2_served: assert property (
    s_req(24'h00ee00, 24'h00eeff, periph_on_o.second_can_enable) |-> route_o.can2)
    else $error("second can not served");
  a_small_ram: assert property (
    s_req(24'h00e000, 24'h00e7ff, 1'b1) |-> route_o.small_ram == periph_on_o.small_ext_ram_enable)
    else $error("small ram route wrong");
  a_gpio_pins: assert property ($stable(periph_on_o) |->
    {can2_pins_gpio_o, can1_pins_gpio_o} == ~periph_on_o[1:0])
    else $error("gpio release wrong");
  a_osc_off: assert property (
    (power_down_i && !periph_on_o.rtc)[*3] |-> !rtc_osc_run_o)
    else $error("oscillator runs in power-down");
  a_osc_choice: assert property (
    (power_down_i && periph_on_o.rtc)[*3] |-> rtc_osc_run_o == !$past(rtc_oscillator_off_i))
    else $error("oscillator ignores off bit");
  a_lock_sticky: assert property (ext_periph_locked_o |=> ext_periph_locked_o)
    else $error("lock bit cleared");
  a_wait_once: assert property (!avs_rsp_o.waitrequest |=> avs_rsp_o.waitrequest)
    else $error("waitrequest low twice");
endmodule
bind xped_top xped_top_asserts u_xped_top_asserts (
  .clock_i(clock_i), .sys_rst_i(sys_rst_i), .avs_req_i(avs_req_i), .avs_rsp_o(avs_rsp_o),
  .emul_mode_i(emul_mode_i), .cpu_req_i(cpu_req_i), .cpu_addr_i(cpu_addr_i), .power_down_i(power_down_i),
  .rtc_oscillator_off_i(rtc_oscillator_off_i), .route_o(route_o), .periph_on_o(periph_on_o),
  .can1_pins_gpio_o(can1_pins_gpio_o), .can2_pins_gpio_o(can2_pins_gpio_o),
  .rtc_osc_run_o(rtc_osc_run_o), .ext_periph_locked_o(ext_periph_locked_o));
`default_nettype wire

// File: sim/xped_cpu_model.sv
`default_nettype none
module xped_cpu_model (
  input  wire logic        clock_i,
  output var  logic        cpu_req_o,
  output var  logic [23:0] cpu_addr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cpu_req_o = 1'b0;
    cpu_addr_o = 24'hffffff;
  end
  // address is scrambled between requests so a stale value never helps
  task automatic access(input logic [23:0] a);
    @(posedge clock_i);
    cpu_req_o <= 1'b1;
    cpu_addr_o <= a;
    @(posedge clock_i);
    cpu_req_o <= 1'b0;
    cpu_addr_o <= ~a;
  endtask
endmodule
`default_nettype wire

// File: sim/xped_top_test.sv
`default_nettype none
module xped_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import xped_pkg::*;
  logic          clock_i = 1'b0;
  logic          sys_rst_i = 1'b1;
  logic          emul = 1'b0;
  logic          pd = 1'b0;
  logic          osc_off = 1'b0;
  logic          cpu_req;
  logic [23:0]   cpu_addr;
  xped_avs_req_t req = '0;
  xped_avs_rsp_t rsp;
  xped_route_t   route;
  xped_enables_t on;
  logic          g1, g2, run, lock;
  logic [31:0]   q;
  logic [4:0]    pec;
  logic [23:0]   a;
  logic [8:0]    e;
  int            miscompares = 0;
  int            checks_done = 0;
  // enables, cpu address, expected route
  logic [37:0]   rows [16] = '{
    {5'h05, 24'h00ef10, 9'h180}, {5'h05, 24'h00ee10, 9'h102}, {5'h05, 24'h00ec00, 9'h102},
    {5'h05, 24'h00e7ff, 9'h120}, {5'h05, 24'h00c000, 9'h104}, {5'h05, 24'h01ef10, 9'h101},
    {5'h1a, 24'h00ef00, 9'h102}, {5'h1a, 24'h00eeff, 9'h140}, {5'h1a, 24'h00ecff, 9'h108},
    {5'h1a, 24'h00e000, 9'h104}, {5'h1a, 24'h00dfff, 9'h110}, {5'h00, 24'h00efff, 9'h104},
    {5'h00, 24'h00ee00, 9'h104}, {5'h00, 24'h00ec10, 9'h104}, {5'h02, 24'h00ee00, 9'h140},
    {5'h02, 24'h00ec10, 9'h102}};
  always #5 clock_i = ~clock_i;
  xped_top u_xped_top (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .avs_req_i(req), .avs_rsp_o(rsp), .emul_mode_i(emul),
    .cpu_req_i(cpu_req), .cpu_addr_i(cpu_addr), .power_down_i(pd), .rtc_oscillator_off_i(osc_off),
    .route_o(route), .periph_on_o(on), .can1_pins_gpio_o(g1), .can2_pins_gpio_o(g2),
    .rtc_osc_run_o(run), .ext_periph_locked_o(lock));
  xped_cpu_model u_xped_cpu_model (.clock_i(clock_i), .cpu_req_o(cpu_req), .cpu_addr_o(cpu_addr));
  // ****
  // tasks
  // ****
  task chk(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      miscompares++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  // waitrequest and readdata are sampled at the rising edge, before that edge's updates land
  task bus(input logic wr, input logic [15:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    req <= '{read: !wr, write: wr, address: ad, writedata: d, byteenable: 4'hf};
    do begin
      @(posedge clock_i);
      n++;
    end while (rsp.waitrequest !== 1'b0 && n < 50);
    q = rsp.readdata;
    req <= '0;
    if (n >= 50) miscompares++;
  endtask
  task tick(input int n);
    repeat (n) @(posedge clock_i);
    @(negedge clock_i);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ****
  // sequence
  // ****
  initial begin
    repeat (4) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    @(negedge clock_i);
    chk(32'({on, g2, g1, run, lock}), 32'h5a);
    bus(1'b0, 16'hf024, '0);
    chk(q, 32'h5);
    bus(1'b0, 16'hf030, '0);
    chk(q, '0);
    foreach (rows[i]) begin
      {pec, a, e} = rows[i];
      bus(1'b1, 16'hf024, 32'(pec));
      bus(1'b0, 16'hf024, '0);
      chk(q, 32'(pec));
      u_xped_cpu_model.access(a);
      @(negedge clock_i);
      chk(32'(route), 32'(e));
      chk(32'({on, g2, g1}), 32'({pec, ~pec[1:0]}));
    end
    bus(1'b1, 16'hf024, '0);
    @(posedge clock_i);
    emul <= 1'b1;
    tick(6);
    chk(32'(on), 32'h1f);
    u_xped_cpu_model.access(24'h00ec20);
    @(negedge clock_i);
    chk(32'(route), 32'h108);
    bus(1'b0, 16'hf024, '0);
    chk(q, '0);
    bus(1'b0, 16'hf02c, '0);
    chk(q, 32'h7f);
    @(posedge clock_i);
    emul <= 1'b0;
    pd <= 1'b1;
    tick(6);
    chk(32'(run), '0);
    bus(1'b1, 16'hf024, 32'h10);
    tick(3);
    chk(32'(run), 32'h1);
    @(posedge clock_i);
    osc_off <= 1'b1;
    tick(2);
    chk(32'(run), '0);
    @(posedge clock_i);
    pd <= 1'b0;
    tick(2);
    chk(32'(run), 32'h1);
    // software sets the enables before locking them
    bus(1'b1, 16'hf024, 32'h5);
    bus(1'b1, 16'hf028, 32'h1);
    bus(1'b1, 16'hf024, 32'h1f);
    bus(1'b1, 16'hf028, '0);
    bus(1'b0, 16'hf024, '0);
    chk(q, 32'h5);
    chk(32'({lock, on}), 32'h25);
    bus(1'b0, 16'hf028, '0);
    chk(q, 32'h1);
    wrap_up();
  end
  initial begin
    #50000;
    miscompares++;
    wrap_up();
  end
endmodule
`default_nettype wire
